// File: verification/t16wm_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module t16wm_pin_load (
    input wire logic drv,
    input wire logic oe,
    output logic level
);
    logic last_r = 1'b0;
    always @(drv or oe)
        if (oe)
            last_r = drv;
    // No pull on the line, so a released pin must not keep its last level
    assign level = oe ? drv : ~last_r;
endmodule
`default_nettype wire

// File: verification/timer16_waveform_modes_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "t16wm_defs.svh"
module timer16_waveform_modes_tb_top;
    logic clk, rst, timer_tick, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, lvl_a;
    logic [15:0] n, v;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 20662;

    t16wm_top t16wm_top_inst (.clk(clk), .rst(rst), .timer_tick(timer_tick),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_a_out(pin_a_out),
        .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
    t16wm_pin_load t16wm_pin_load_inst (.drv(pin_a_out), .oe(pin_a_oe),
        .level(lvl_a));

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pin register word with only state A and direction A set
    function automatic logic [31:0] exp_pin(input logic sa, input logic da);
        return {26'h0, 1'b0, sa, 1'b0, da, 2'b00};
    endfunction

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'h3;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge clk);
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
        end
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        rst = 1'b1;
        timer_tick = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `T16WM_ADDR_PIN, 32'h0);
        chk("pin reg", 32'h0, rd);
        bus(1'b1, `T16WM_ADDR_CTRL, 32'h30);
        bus(1'b1, `T16WM_ADDR_FORCE, 32'h1);
        bus(1'b0, `T16WM_ADDR_PIN, 32'h0);
        chk("state a", 32'h10, rd);
        chk("oe a", 32'h0, {31'h0, pin_a_oe});
        bus(1'b0, `T16WM_ADDR_FLAGS, 32'h0);
        chk("flags", 32'h0, rd);
        bus(1'b1, `T16WM_ADDR_PIN, 32'h4);
        repeat (2) @(posedge clk);
        chk("level a", 32'h1, {31'h0, lvl_a});
        bus(1'b1, `T16WM_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("port a", 32'h0, {31'h0, pin_a_out});
        v = 16'($random(seed));
        bus(1'b1, `T16WM_ADDR_COUNT, {16'h0, v});
        bus(1'b0, `T16WM_ADDR_COUNT, 32'h0);
        chk("count", {16'h0, v}, rd);
        bus(1'b1, `T16WM_ADDR_COUNT, 32'hffff);
        tick(1);
        bus(1'b0, `T16WM_ADDR_COUNT, 32'h0);
        chk("wrap", 32'h0, rd);
        bus(1'b0, `T16WM_ADDR_FLAGS, 32'h0);
        chk("overflow", 32'h1, rd);
        bus(1'b1, `T16WM_ADDR_FLAGS, 32'hf);
        n = 16'h3 + 16'($unsigned($random(seed)) % 8);
        bus(1'b1, `T16WM_ADDR_CMP_A, {16'h0, n});
        bus(1'b1, `T16WM_ADDR_CTRL, 32'h14);
        bus(1'b1, `T16WM_ADDR_COUNT, 32'h0);
        tick(int'(n) + 1);
        bus(1'b0, `T16WM_ADDR_COUNT, 32'h0);
        chk("ctc count", 32'h0, rd);
        bus(1'b0, `T16WM_ADDR_FLAGS, 32'h0);
        chk("ctc flags", 32'h2, rd);
        bus(1'b0, `T16WM_ADDR_PIN, 32'h0);
        chk("toggle", 32'h4, rd);
        bus(1'b1, `T16WM_ADDR_FLAGS, 32'hf);
        bus(1'b1, `T16WM_ADDR_CTRL, 32'h25);
        bus(1'b1, `T16WM_ADDR_COUNT, 32'hfe);
        tick(2);
        bus(1'b0, `T16WM_ADDR_COUNT, 32'h0);
        chk("pwm top", 32'h0, rd);
        bus(1'b1, `T16WM_ADDR_FLAGS, 32'hf);
        tick(int'(n) + 1);
        bus(1'b0, `T16WM_ADDR_PIN, 32'h0);
        chk("pwm set", 32'h14, rd);
        bus(1'b0, `T16WM_ADDR_FLAGS, 32'h0);
        chk("pwm flags", 32'h6, rd);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `T16WM_ADDR_PIN, 32'h0);
        chk("reset pin", exp_pin(1'b0, 1'b0), rd);
        chk("reset oe", 32'h0, {31'h0, pin_a_oe});
        bus(1'b1, `T16WM_ADDR_CMP_A, {16'h0, n});
        bus(1'b1, `T16WM_ADDR_CTRL, 32'h1f);
        bus(1'b1, `T16WM_ADDR_CMP_A, {16'h0, n + 16'h2});
        bus(1'b1, `T16WM_ADDR_COUNT, 32'h0);
        tick(int'(n) + 1);
        bus(1'b0, `T16WM_ADDR_COUNT, 32'h0);
        chk("top 15", 32'h0, rd);
        bus(1'b0, `T16WM_ADDR_FLAGS, 32'h0);
        chk("flags 15", 32'h3, rd);
        bus(1'b0, `T16WM_ADDR_PIN, 32'h0);
        chk("toggle 15", exp_pin(1'b1, 1'b0), rd);
        bus(1'b1, `T16WM_ADDR_PIN, 32'ha);
        repeat (2) @(posedge clk);
        chk("port b", 32'h1, {31'h0, pin_b_out});
        chk("oe b", 32'h1, {31'h0, pin_b_oe});
        conclude();
    end
endmodule
`default_nettype wire

// File: verilog/t16wm_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "t16wm_defs.svh"
module t16wm_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [3:0] mode,
    input wire logic cnt_load,
    input wire logic [15:0] cnt_wdata,
    input wire logic [15:0] ocr_a,
    input wire logic [15:0] capture,
    output logic [15:0] cnt,
    output logic blocked,
    output logic top_hit,
    output logic ovf_evt
);
    t16wm_pkg::t16wm_class_type cls;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] top_value;
    logic block_r;

    assign cls = t16wm_pkg::t16wm_mode_class(mode); // RULE9
    assign cnt = cnt_r;
    assign blocked = block_r;

    always_comb
    begin
        unique case (mode)
            `T16WM_MODE_FPWM8: top_value = `T16WM_TOP_8BIT; // RULE20
            `T16WM_MODE_FPWM9: top_value = `T16WM_TOP_9BIT; // RULE20
            `T16WM_MODE_FPWM10: top_value = `T16WM_TOP_10BIT; // RULE20
            `T16WM_MODE_CTC_A, `T16WM_MODE_FPWM_A: top_value = ocr_a; // RULE13
            `T16WM_MODE_CTC_CAP, `T16WM_MODE_FPWM_CAP: top_value = capture;
            default: top_value = `T16WM_MAX;
        endcase
    end

    // Equality only: a TOP written below the count is missed
    always_comb
    begin
        top_hit = tick && !block_r && cnt_r == top_value && // RULE15
            (cls == t16wm_pkg::T16WM_CLS_CTC ||
            cls == t16wm_pkg::T16WM_CLS_FPWM);
        ovf_evt = tick && (cnt_r == `T16WM_MAX || // RULE11 RULE17
            (cls == t16wm_pkg::T16WM_CLS_FPWM && top_hit));
        if (top_hit)
        begin
            cnt_nxt = `T16WM_BOTTOM; // RULE13 RULE18 RULE21
        end
        else
        begin
            cnt_nxt = cnt_r + 16'h0001; // RULE10
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= `T16WM_BOTTOM;
        end
        else if (cnt_load)
        begin
            cnt_r <= cnt_wdata; // RULE12
        end
        else if (tick)
        begin
            cnt_r <= cnt_nxt;
        end
    end

    // A counter write masks matches for one timer tick
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            block_r <= 1'b0;
        end
        else if (cnt_load)
        begin
            block_r <= 1'b1;
        end
        else if (tick)
        begin
            block_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verilog/t16wm_defs.svh
// How it works
// RULE1 - Action field picks match action and pin source
// RULE2 - Reset clears the internal output state
// RULE3 - Nonzero action puts output state on pin
// RULE4 - Pin shows state only when direction is output
// RULE5 - Output state settable while pin disabled
// RULE6 - Action field never touches capture logic
// RULE7 - Action zero leaves output state unchanged
// RULE8 - New action acts at next match; force acts now
// RULE9 - Counting depends only on the mode field
// RULE10 - Normal mode increments and wraps to zero
// RULE11 - Normal mode sets overflow as counter hits zero
// RULE12 - Normal mode accepts counter writes any time
// RULE13 - Clear-on-match clears counter at compare A or capture
// RULE14 - Clear-on-match sets flag of TOP register
// RULE15 - Clear-on-match TOP unbuffered; missed match wraps
// RULE16 - Clear-on-match action one toggles channel A
// RULE17 - Clear-on-match sets overflow on max rollover
// RULE18 - Fast PWM counts single slope bottom to top
// RULE19 - Fast PWM set/clear on match, opposite at top; here action two sets on match and action three clears on match
// RULE20 - Fast PWM top fixed, capture, or compare A
// RULE21 - Fast PWM clears counter tick after top
// RULE22 - Software keeps register TOP at least three
// RULE23 - Fast PWM sets channel flag on match
// RULE24 - Compares buffered in PWM, direct otherwise
// RULE25 - Force updates state without flag or clear
// RULE26 - Pin driven only when direction bit is one
`ifndef T16WM_DEFS_SVH
`define T16WM_DEFS_SVH

`define T16WM_ADDR_CTRL 5'h00
`define T16WM_ADDR_FORCE 5'h04
`define T16WM_ADDR_COUNT 5'h08
`define T16WM_ADDR_CMP_A 5'h0c
`define T16WM_ADDR_CMP_B 5'h10
`define T16WM_ADDR_CAPTURE 5'h14
`define T16WM_ADDR_FLAGS 5'h18
`define T16WM_ADDR_PIN 5'h1c

`define T16WM_CTRL_MODE_MSB 3
`define T16WM_CTRL_MODE_LSB 0
`define T16WM_CTRL_ACT_A_MSB 5
`define T16WM_CTRL_ACT_A_LSB 4
`define T16WM_CTRL_ACT_B_MSB 7
`define T16WM_CTRL_ACT_B_LSB 6

`define T16WM_FORCE_A_BIT 0
`define T16WM_FORCE_B_BIT 1

`define T16WM_FLAG_OVF_BIT 0
`define T16WM_FLAG_CMP_A_BIT 1
`define T16WM_FLAG_CMP_B_BIT 2
`define T16WM_FLAG_CAP_BIT 3

`define T16WM_PIN_PORT_A_BIT 0
`define T16WM_PIN_PORT_B_BIT 1
`define T16WM_PIN_DIR_A_BIT 2
`define T16WM_PIN_DIR_B_BIT 3
`define T16WM_PIN_STATE_A_BIT 4
`define T16WM_PIN_STATE_B_BIT 5

`define T16WM_MODE_NORMAL 4'h0
`define T16WM_MODE_CTC_A 4'h4
`define T16WM_MODE_FPWM8 4'h5
`define T16WM_MODE_FPWM9 4'h6
`define T16WM_MODE_FPWM10 4'h7
`define T16WM_MODE_CTC_CAP 4'hc
`define T16WM_MODE_FPWM_CAP 4'he
`define T16WM_MODE_FPWM_A 4'hf

`define T16WM_TOP_8BIT 16'h00ff
`define T16WM_TOP_9BIT 16'h01ff
`define T16WM_TOP_10BIT 16'h03ff
`define T16WM_MAX 16'hffff
`define T16WM_BOTTOM 16'h0000

`define T16WM_ACT_NONE 2'h0
`define T16WM_ACT_TOGGLE 2'h1
`define T16WM_ACT_CLEAR 2'h2
`define T16WM_ACT_SET 2'h3

`define T16WM_RESET_STATE 1'b0

`endif

// File: verilog/t16wm_outunit.sv
`timescale 1ns/1ps
`default_nettype none
`include "t16wm_defs.svh"
module t16wm_outunit (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] action,
    input wire t16wm_pkg::t16wm_class_type cls,
    input wire logic toggle_ok,
    input wire logic match,
    input wire logic top_evt,
    input wire logic force_strobe,
    output logic state
);
    logic state_r;
    logic state_nxt;
    logic non_pwm;

    assign state = state_r;
    assign non_pwm = cls == t16wm_pkg::T16WM_CLS_NORMAL ||
        cls == t16wm_pkg::T16WM_CLS_CTC;

    always_comb
    begin
        state_nxt = state_r;
        if (non_pwm && (match || force_strobe)) // RULE8 RULE25
        begin
            unique case (action) // RULE1
                `T16WM_ACT_NONE: state_nxt = state_r; // RULE7
                `T16WM_ACT_TOGGLE: state_nxt = !state_r; // RULE16
                `T16WM_ACT_CLEAR: state_nxt = 1'b0;
                `T16WM_ACT_SET: state_nxt = 1'b1;
            endcase
        end
        else if (cls == t16wm_pkg::T16WM_CLS_FPWM)
        begin
            // Match wins over TOP so compare equal to TOP holds steady
            unique case (action)
                `T16WM_ACT_NONE: state_nxt = state_r; // RULE7
                `T16WM_ACT_TOGGLE:
                    state_nxt = (toggle_ok && match) ? !state_r : state_r;
                `T16WM_ACT_CLEAR:
                    state_nxt = match || (!top_evt && state_r); // RULE19
                `T16WM_ACT_SET:
                    state_nxt = !match && (top_evt || state_r); // RULE19
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= `T16WM_RESET_STATE; // RULE2
        end
        else
        begin
            state_r <= state_nxt;
        end
    end
endmodule
`default_nettype wire

// File: verilog/t16wm_pkg.sv
`include "t16wm_defs.svh"
package t16wm_pkg;

typedef enum logic [1:0] {
    T16WM_CLS_NORMAL,
    T16WM_CLS_CTC,
    T16WM_CLS_FPWM,
    T16WM_CLS_OTHER
} t16wm_class_type;

function automatic t16wm_class_type t16wm_mode_class(input logic [3:0] mode);
    t16wm_class_type cls;
    cls = T16WM_CLS_OTHER;
    unique case (mode)
        `T16WM_MODE_NORMAL: cls = T16WM_CLS_NORMAL;
        `T16WM_MODE_CTC_A, `T16WM_MODE_CTC_CAP: cls = T16WM_CLS_CTC;
        `T16WM_MODE_FPWM8, `T16WM_MODE_FPWM9, `T16WM_MODE_FPWM10,
        `T16WM_MODE_FPWM_CAP, `T16WM_MODE_FPWM_A: cls = T16WM_CLS_FPWM;
        default: cls = T16WM_CLS_OTHER;
    endcase
    return cls;
endfunction

function automatic logic [15:0] t16wm_merge16(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [1:0] be);
    logic [15:0] res;
    res = old_v;
    if (be[0])
    begin
        res[7:0] = new_v[7:0];
    end
    if (be[1])
    begin
        res[15:8] = new_v[15:8];
    end
    return res;
endfunction

endpackage

// File: verilog/t16wm_top.sv
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "t16wm_defs.svh"
module t16wm_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic timer_tick,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);
    logic waitreq_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_mux;
    logic do_wr;
    logic [3:0] mode_r;
    logic [1:0] act_a_r;
    logic [1:0] act_b_r;
    logic [15:0] buf_a_r;
    logic [15:0] buf_b_r;
    logic [15:0] eff_a_r;
    logic [15:0] eff_b_r;
    logic [15:0] capture_r;
    logic [3:0] flags_r;
    logic [3:0] flags_set;
    logic [3:0] flags_clr;
    logic port_a_r;
    logic port_b_r;
    logic dir_a_r;
    logic dir_b_r;
    logic pin_a_out_r;
    logic pin_a_oe_r;
    logic pin_b_out_r;
    logic pin_b_oe_r;
    logic [15:0] cnt;
    logic blocked;
    logic top_hit;
    logic ovf_evt;
    logic cnt_load;
    logic match_a;
    logic match_b;
    logic force_a;
    logic force_b;
    logic state_a;
    logic state_b;
    logic buffered;
    logic wr_ctrl;
    logic wr_cmp_a;
    logic wr_cmp_b;
    t16wm_pkg::t16wm_class_type cls;

    assign avs_waitrequest = waitreq_r;
    assign avs_readdata = readdata_r;
    assign pin_a_out = pin_a_out_r;
    assign pin_a_oe = pin_a_oe_r;
    assign pin_b_out = pin_b_out_r;
    assign pin_b_oe = pin_b_oe_r;

    // Request is taken on the edge where waitrequest is seen low
    assign do_wr = avs_write && !waitreq_r;
    assign wr_ctrl = do_wr && avs_address == `T16WM_ADDR_CTRL &&
        avs_byteenable[0];
    assign wr_cmp_a = do_wr && avs_address == `T16WM_ADDR_CMP_A &&
        |avs_byteenable[1:0];
    assign wr_cmp_b = do_wr && avs_address == `T16WM_ADDR_CMP_B &&
        |avs_byteenable[1:0];
    assign cnt_load = do_wr && avs_address == `T16WM_ADDR_COUNT &&
        |avs_byteenable[1:0];

    assign cls = t16wm_pkg::t16wm_mode_class(mode_r);
    assign buffered = cls == t16wm_pkg::T16WM_CLS_FPWM ||
        cls == t16wm_pkg::T16WM_CLS_OTHER;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            waitreq_r <= 1'b1;
        end
        else if (waitreq_r && (avs_read || avs_write))
        begin
            waitreq_r <= 1'b0;
        end
        else
        begin
            waitreq_r <= 1'b1;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            `T16WM_ADDR_CTRL:
                rd_mux[7:0] = {act_b_r, act_a_r, mode_r};
            `T16WM_ADDR_COUNT: rd_mux[15:0] = cnt;
            `T16WM_ADDR_CMP_A: rd_mux[15:0] = buf_a_r;
            `T16WM_ADDR_CMP_B: rd_mux[15:0] = buf_b_r;
            `T16WM_ADDR_CAPTURE: rd_mux[15:0] = capture_r;
            `T16WM_ADDR_FLAGS: rd_mux[3:0] = flags_r;
            `T16WM_ADDR_PIN:
                rd_mux[5:0] = {state_b, state_a, dir_b_r, dir_a_r,
                    port_b_r, port_a_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is latched once and stands while waitrequest is low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readdata_r <= 32'h0000_0000;
        end
        else if (waitreq_r && avs_read)
        begin
            readdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= `T16WM_MODE_NORMAL;
            act_a_r <= `T16WM_ACT_NONE;
            act_b_r <= `T16WM_ACT_NONE;
        end
        else if (wr_ctrl)
        begin
            mode_r <= avs_writedata[`T16WM_CTRL_MODE_MSB:`T16WM_CTRL_MODE_LSB];
            act_a_r <=
                avs_writedata[`T16WM_CTRL_ACT_A_MSB:`T16WM_CTRL_ACT_A_LSB];
            act_b_r <=
                avs_writedata[`T16WM_CTRL_ACT_B_MSB:`T16WM_CTRL_ACT_B_LSB];
        end
    end

    // Capture register is plain storage; action bits never reach it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            capture_r <= `T16WM_BOTTOM;
        end
        else if (do_wr && avs_address == `T16WM_ADDR_CAPTURE &&
            |avs_byteenable[1:0])
        begin
            capture_r <= t16wm_pkg::t16wm_merge16(capture_r, // RULE6 RULE15
                avs_writedata[15:0], avs_byteenable[1:0]);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            buf_a_r <= `T16WM_BOTTOM;
            buf_b_r <= `T16WM_BOTTOM;
        end
        else
        begin
            if (wr_cmp_a)
            begin
                buf_a_r <= t16wm_pkg::t16wm_merge16(buf_a_r,
                    avs_writedata[15:0], avs_byteenable[1:0]);
            end
            if (wr_cmp_b)
            begin
                buf_b_r <= t16wm_pkg::t16wm_merge16(buf_b_r,
                    avs_writedata[15:0], avs_byteenable[1:0]);
            end
        end
    end

    // PWM copies the buffer at TOP to avoid odd-length pulses
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            eff_a_r <= `T16WM_BOTTOM;
            eff_b_r <= `T16WM_BOTTOM;
        end
        else if (buffered)
        begin
            if (top_hit)
            begin
                eff_a_r <= buf_a_r; // RULE24
                eff_b_r <= buf_b_r; // RULE24
            end
        end
        else
        begin
            if (wr_cmp_a)
            begin
                eff_a_r <= t16wm_pkg::t16wm_merge16(buf_a_r, // RULE24
                    avs_writedata[15:0], avs_byteenable[1:0]);
            end
            if (wr_cmp_b)
            begin
                eff_b_r <= t16wm_pkg::t16wm_merge16(buf_b_r, // RULE24
                    avs_writedata[15:0], avs_byteenable[1:0]);
            end
        end
    end

    t16wm_counter u_counter (
        .clk(clk),
        .rst(rst),
        .tick(timer_tick),
        .mode(mode_r),
        .cnt_load(cnt_load),
        .cnt_wdata(t16wm_pkg::t16wm_merge16(cnt, avs_writedata[15:0],
            avs_byteenable[1:0])),
        .ocr_a(eff_a_r),
        .capture(capture_r),
        .cnt(cnt),
        .blocked(blocked),
        .top_hit(top_hit),
        .ovf_evt(ovf_evt)
    );

    assign match_a = timer_tick && !blocked && cnt == eff_a_r;
    assign match_b = timer_tick && !blocked && cnt == eff_b_r; // RULE23
    // Force is honoured only outside PWM and may run with pin disabled
    assign force_a = do_wr && avs_address == `T16WM_ADDR_FORCE && // RULE5
        avs_byteenable[0] && avs_writedata[`T16WM_FORCE_A_BIT] && !buffered;
    assign force_b = do_wr && avs_address == `T16WM_ADDR_FORCE &&
        avs_byteenable[0] && avs_writedata[`T16WM_FORCE_B_BIT] && !buffered;

    t16wm_outunit u_out_a (
        .clk(clk),
        .rst(rst),
        .action(act_a_r),
        .cls(cls),
        .toggle_ok(mode_r == `T16WM_MODE_FPWM_A),
        .match(match_a),
        .top_evt(top_hit),
        .force_strobe(force_a),
        .state(state_a)
    );

    t16wm_outunit u_out_b (
        .clk(clk),
        .rst(rst),
        .action(act_b_r),
        .cls(cls),
        .toggle_ok(1'b0),
        .match(match_b),
        .top_evt(top_hit),
        .force_strobe(force_b),
        .state(state_b)
    );

    // Force never sets flags; only true matches and overflows do
    always_comb
    begin
        flags_set = 4'h0;
        flags_set[`T16WM_FLAG_OVF_BIT] = ovf_evt; // RULE11 RULE17
        flags_set[`T16WM_FLAG_CMP_A_BIT] = match_a; // RULE14 RULE25
        flags_set[`T16WM_FLAG_CMP_B_BIT] = match_b; // RULE23
        flags_set[`T16WM_FLAG_CAP_BIT] = top_hit && // RULE14
            (mode_r == `T16WM_MODE_CTC_CAP ||
            mode_r == `T16WM_MODE_FPWM_CAP);
        flags_clr = 4'h0;
        if (do_wr && avs_address == `T16WM_ADDR_FLAGS && avs_byteenable[0])
        begin
            flags_clr = avs_writedata[3:0];
        end
    end

    // Set beats a same-cycle clear so no event is lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_r <= 4'h0;
        end
        else
        begin
            flags_r <= (flags_r & ~flags_clr) | flags_set;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_a_r <= 1'b0;
            port_b_r <= 1'b0;
            dir_a_r <= 1'b0;
            dir_b_r <= 1'b0;
        end
        else if (do_wr && avs_address == `T16WM_ADDR_PIN && avs_byteenable[0])
        begin
            port_a_r <= avs_writedata[`T16WM_PIN_PORT_A_BIT];
            port_b_r <= avs_writedata[`T16WM_PIN_PORT_B_BIT];
            dir_a_r <= avs_writedata[`T16WM_PIN_DIR_A_BIT];
            dir_b_r <= avs_writedata[`T16WM_PIN_DIR_B_BIT];
        end
    end

    // Pin source swaps as soon as action goes nonzero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_a_out_r <= 1'b0;
            pin_b_out_r <= 1'b0;
            pin_a_oe_r <= 1'b0;
            pin_b_oe_r <= 1'b0;
        end
        else
        begin
            pin_a_out_r <= (|act_a_r) ? state_a : port_a_r; // RULE3
            pin_b_out_r <= (|act_b_r) ? state_b : port_b_r; // RULE1
            pin_a_oe_r <= dir_a_r; // RULE4 RULE26
            pin_b_oe_r <= dir_b_r; // RULE26
        end
    end

    normal_ovf_a: assert property (@(posedge clk) disable iff (rst) // RULE11
        timer_tick && mode_r == `T16WM_MODE_NORMAL && cnt == `T16WM_MAX &&
        !cnt_load |=> flags_r[`T16WM_FLAG_OVF_BIT] && cnt == `T16WM_BOTTOM)
        else $error("overflow not set on wrap");

    normal_count_a: assert property (@(posedge clk) disable iff (rst) // RULE10
        timer_tick && mode_r == `T16WM_MODE_NORMAL && !cnt_load
        |=> cnt == $past(cnt) + 16'h0001)
        else $error("normal mode did not increment");

    ctc_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE13
        timer_tick && !blocked && mode_r == `T16WM_MODE_CTC_A &&
        cnt == eff_a_r && !cnt_load |=> cnt == `T16WM_BOTTOM ##0
        flags_r[`T16WM_FLAG_CMP_A_BIT])
        else $error("clear on match A failed");

    ctc_toggle_a: assert property (@(posedge clk) disable iff (rst) // RULE16
        match_a && cls == t16wm_pkg::T16WM_CLS_CTC &&
        act_a_r == `T16WM_ACT_TOGGLE |=> state_a != $past(state_a))
        else $error("channel A did not toggle");

    action_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE7
        act_a_r == `T16WM_ACT_NONE |=> $stable(state_a))
        else $error("state moved with action zero");

    pin_override_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        act_a_r != `T16WM_ACT_NONE ##1 1'b1
        |-> pin_a_out == $past(state_a))
        else $error("pin not driven from state");

    pin_dir_a: assert property (@(posedge clk) disable iff (rst) // RULE26
        !dir_a_r ##1 !dir_a_r |-> !pin_a_oe)
        else $error("pin enabled with direction input");

    fpwm_top_a: assert property (@(posedge clk) disable iff (rst) // RULE19
        top_hit && !match_a && cls == t16wm_pkg::T16WM_CLS_FPWM &&
        act_a_r == `T16WM_ACT_CLEAR |=> !state_a)
        else $error("non-inverting output not cleared at top");

    fpwm_restart_a: assert property (@(posedge clk) disable iff (rst) // RULE21
        top_hit && cls == t16wm_pkg::T16WM_CLS_FPWM && !cnt_load
        |=> cnt == `T16WM_BOTTOM && flags_r[`T16WM_FLAG_OVF_BIT])
        else $error("fast PWM did not restart at bottom");

    cmp_buffer_a: assert property (@(posedge clk) disable iff (rst) // RULE24
        buffered && !top_hit |=> eff_a_r == $past(eff_a_r))
        else $error("buffered compare changed off top");
endmodule
`default_nettype wire
